// ### pkg/uart_status_defs.vh
`ifndef UART_STATUS_DEFS_VH
`define UART_STATUS_DEFS_VH

// =====================================================
// Register addresses on the three address lines
`define ADDR_DATA        3'h0
`define ADDR_IE_MASK     3'h1
`define ADDR_INT_ID      3'h2
`define ADDR_LINE_CTRL   3'h3
`define ADDR_MODEM_CTRL  3'h4
`define ADDR_LINE_STAT   3'h5
`define ADDR_MODEM_STAT  3'h6

// =====================================================
// Line status field positions
`define LS_READY     0
`define LS_OVERRUN   1
`define LS_PARITY    2
`define LS_FRAMING   3
`define LS_BREAK     4
`define LS_THR_EMPTY 5
`define LS_TSR_EMPTY 6

// =====================================================
// Interrupt enable field positions
`define IE_RX_DATA   0
`define IE_THR_EMPTY 1
`define IE_LINE_STAT 2
`define IE_MODEM     3

// =====================================================
// Modem control field positions
`define MC_DTR       0
`define MC_RTS       1
`define MC_AUX1      2
`define MC_AUX2      3
`define MC_LOOP      4

// =====================================================
// Interrupt identification codes, bits 2 down to 0
`define ID_NONE      3'h1
`define ID_LINE_STAT 3'h6
`define ID_RX_DATA   3'h4
`define ID_THR_EMPTY 3'h2
`define ID_MODEM     3'h0

// =====================================================
// Reset values
`define RST_LINE_STAT  8'h60
`define RST_INT_ID     8'h01
`define RST_IE_MASK    8'h00
`define RST_MODEM_CTRL 8'h00

// =====================================================
// Character timing in bit times
`define BITS_START     5'h01
`define BITS_MIN_DATA  5'h05

`endif

// ### verif/modem_model.sv
// ==========
// Data set on the serial and modem lines
module modem_model (
  input  wire logic       clock_i,
  input  wire logic       space_i,   // Hold line at spacing
  input  wire logic [3:0] on_i,      // Asserted lines: cts dsr ring carrier
  output logic            serial_o = 1'b1,
  output logic [3:0]      pins_n_o = 4'hf
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines change just after the edge; idle is marking
  always @(posedge clock_i) begin
    serial_o <= !space_i;
    pins_n_o <= ~on_i;
  end
endmodule

// ### verif/test_uart_status_interrupt_modem_ctrl.sv
module test_uart_status_interrupt_modem_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, nrst_i = 1'b0, sel_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0, keep_sel = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, rx_char_i = 8'h00;
  logic [1:0] word_len_i = 2'h3;
  logic dlab_i = 1'b0, two_stop_i = 1'b0, parity_en_i = 1'b0, even_parity_i = 1'b1, bit_tick_i = 1'b0;
  logic rx_char_valid_i = 1'b0, rx_parity_bit_i = 1'b0, rx_stop_bit_i = 1'b1, space = 1'b0;
  logic tx_load_i = 1'b0, tx_shifter_idle_i = 1'b1, tx_serial_i = 1'b1;
  logic [3:0] modem_on = 4'h0, pins_n;
  wire [7:0] rdata_o, tx_holding_o;
  wire rx_serial_o, tx_holding_full_o, serial_in, serial_out_o, dtr_out_n_o, rts_out_n_o;
  wire aux1_out_n_o, aux2_out_n_o, irq_output_o;
  int miscompares = 0, num_checks = 0, cycles = 0;
  always #25 clock_i = ~clock_i;
  uart_status_interrupt_modem_ctrl dut (.clock_i, .nrst_i, .sel_i, .addr_i, .rd_i, .wr_i, .wdata_i,
    .rdata_o, .dlab_i, .word_len_i, .two_stop_i, .parity_en_i, .even_parity_i, .bit_tick_i,
    .rx_char_valid_i, .rx_char_i, .rx_parity_bit_i, .rx_stop_bit_i, .rx_serial_o, .tx_load_i,
    .tx_shifter_idle_i, .tx_serial_i, .tx_holding_o, .tx_holding_full_o, .serial_in_i(serial_in),
    .serial_out_o, .cts_in_n_i(pins_n[0]), .dsr_in_n_i(pins_n[1]), .ring_in_n_i(pins_n[2]),
    .carrier_detect_in_n_i(pins_n[3]), .dtr_out_n_o, .rts_out_n_o, .aux1_out_n_o, .aux2_out_n_o,
    .irq_output_o);
  modem_model far (.clock_i, .space_i(space), .on_i(modem_on), .serial_o(serial_in), .pins_n_o(pins_n));
  // ==========
  // Shared tasks
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    {sel_i, wr_i, addr_i, wdata_i} <= {2'b11, a, d};
    @(posedge clock_i);
    {sel_i, wr_i} <= {keep_sel, 1'b0};
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock_i);
    {sel_i, rd_i, addr_i} <= {2'b11, a};
    @(posedge clock_i);
    {sel_i, rd_i} <= {keep_sel, 1'b0};
    #1 chk(rdata_o, e);
    @(posedge clock_i);
  endtask
  task automatic pins(input logic [7:0] e);
    repeat (6) @(posedge clock_i);
    #1 chk({2'h0, serial_out_o, dtr_out_n_o, rts_out_n_o, aux1_out_n_o, aux2_out_n_o, irq_output_o}, e);
  endtask
  task automatic rx(input logic [7:0] c, input logic p, input logic s);
    @(posedge clock_i);
    {rx_char_valid_i, rx_char_i, rx_parity_bit_i, rx_stop_bit_i} <= {1'b1, c, p, s};
    @(posedge clock_i);
    rx_char_valid_i <= 1'b0;
  endtask
  task automatic pulse_load;
    @(posedge clock_i);
    {tx_load_i, tx_shifter_idle_i} <= 2'b10;
    @(posedge clock_i);
    tx_load_i <= 1'b0;
  endtask
  task automatic tick;
    @(posedge clock_i);
    bit_tick_i <= 1'b1;
    @(posedge clock_i);
    bit_tick_i <= 1'b0;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    rdc(3'h5, 8'h60);
    rdc(3'h2, 8'h01);
    rdc(3'h1, 8'h00);
    pins(8'h3e);
    $display("reset test done");
  endtask
  task automatic t_receive;
    wr(3'h1, 8'h07);
    parity_en_i <= 1'b1;
    rx(8'h01, 1'b0, 1'b1);
    rdc(3'h2, 8'h06);
    pins(8'h3f);
    rdc(3'h5, 8'h65);
    rdc(3'h2, 8'h04);
    rx(8'h03, 1'b0, 1'b0);
    rdc(3'h2, 8'h06);
    rdc(3'h5, 8'h6b);
    rdc(3'h5, 8'h61);
    rdc(3'h0, 8'h03);
    rdc(3'h2, 8'h01);
    rx(8'h55, 1'b0, 1'b1);
    wr(3'h5, 8'h00);
    rdc(3'h5, 8'h60);
    wr(3'h1, 8'h00);
    parity_en_i <= 1'b0;
    $display("receive test done");
  endtask
  task automatic t_transmit;
    wr(3'h1, 8'h03);
    wr(3'h0, 8'h5a);
    rdc(3'h5, 8'h40);
    pulse_load();
    rdc(3'h5, 8'h20);
    keep_sel = 1'b1;
    {sel_i, addr_i} <= {1'b1, 3'h2};
    rx(8'h00, 1'b0, 1'b1);
    rdc(3'h2, 8'h02);
    keep_sel = 1'b0;
    @(posedge clock_i);
    sel_i <= 1'b0;
    rdc(3'h0, 8'h00);
    rdc(3'h2, 8'h01);
    pulse_load();
    pins(8'h3f);
    wr(3'h0, 8'ha5);
    pins(8'h3e);
    pulse_load();
    tx_shifter_idle_i <= 1'b1;
    wr(3'h1, 8'h00);
    rdc(3'h5, 8'h60);
    $display("transmit test done");
  endtask
  task automatic t_modem;
    wr(3'h4, 8'h0f);
    pins(8'h20);
    wr(3'h4, 8'h05);
    pins(8'h2a);
    wr(3'h1, 8'h08);
    space <= 1'b1;
    wr(3'h4, 8'h1f);
    pins(8'h3f);
    rdc(3'h2, 8'h00);
    rdc(3'h6, 8'hfb);
    rdc(3'h6, 8'hf0);
    rdc(3'h2, 8'h01);
    tx_serial_i <= 1'b0;
    pins(8'h3e);
    chk({7'h00, rx_serial_o}, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h00);
    {space, tx_serial_i} <= 2'b01;
    pins(8'h3e);
    rdc(3'h6, 8'h0f);
    modem_on <= 4'h1;
    pins(8'h3e);
    rdc(3'h6, 8'h11);
    modem_on <= 4'h0;
    $display("modem test done");
  endtask
  task automatic t_spacing;
    {word_len_i, space} <= 3'b001;
    repeat (4) @(posedge clock_i);
    repeat (7) tick();
    rdc(3'h5, 8'h60);
    tick();
    wr(3'h1, 8'h0b);
    rdc(3'h2, 8'h02);
    wr(3'h1, 8'h00);
    rdc(3'h5, 8'h70);
    rdc(3'h5, 8'h60);
    {word_len_i, space} <= 3'b110;
    $display("spacing test done");
  endtask
  // ==========
  // Main sequence and hang guard
  initial begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset();
    t_receive();
    t_transmit();
    t_modem();
    t_spacing();
    end_of_test();
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
endmodule

// ### verif/uart_sim_checker.sv
// ==========
// Port-level checker
module uart_sim_checker (
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic [2:0] addr_i,
  input wire logic       rd_i,
  input wire logic       wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       dlab_i,
  input wire logic       tx_load_i,
  input wire logic       tx_serial_i,
  input wire logic [7:0] tx_holding_o,
  input wire logic       tx_holding_full_o,
  input wire logic       rx_serial_o,
  input wire logic       serial_out_o,
  input wire logic       dtr_out_n_o,
  input wire logic       rts_out_n_o,
  input wire logic       irq_output_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] mc_q;  // Shadow of modem control
  logic [3:0] ie_q;  // Shadow of enable mask
  logic [1:0] lp_q;  // Loopback bit history
  // ==========
  // Shadow registers follow host writes
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mc_q <= 5'h00;
      ie_q <= 4'h0;
      lp_q <= 2'h0;
    end else begin
      lp_q <= {lp_q[0], mc_q[4]};
      if (wr_i && addr_i == 3'h4) begin
        mc_q <= wdata_i[4:0];
      end
      if (wr_i && addr_i == 3'h1 && !dlab_i) begin
        ie_q <= wdata_i[3:0];
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_mc_wr;
    wr_i && addr_i == 3'h4;
  endsequence
  sequence s_loop_held;
    lp_q[0] ##1 lp_q[0];
  endsequence
  AST_MC_PIN: assert property (s_mc_wr |-> ##2 dtr_out_n_o == (mc_q[4] | !mc_q[0]))
    else $error("terminal ready pin wrong");
  AST_LOOP_PINS: assert property (s_loop_held |-> serial_out_o && dtr_out_n_o && rts_out_n_o)
    else $error("loopback pins not inactive");
  AST_LOOP_RX: assert property (s_loop_held |-> rx_serial_o == $past(tx_serial_i))
    else $error("loopback receive line wrong");
  AST_IRQ_MASK: assert property (ie_q == 4'h0 && $past(ie_q) == 4'h0 |-> !irq_output_o)
    else $error("interrupt while all masked");
  AST_HOLD_LOAD: assert property (wr_i && addr_i == 3'h0 && !dlab_i && !tx_load_i
    |=> tx_holding_full_o && tx_holding_o == $past(wdata_i))
    else $error("holding register not loaded");
  AST_LOAD_CLR: assert property (tx_load_i && !wr_i |=> !tx_holding_full_o)
    else $error("holding not emptied");
  AST_LS_TOP: assert property (rd_i && addr_i == 3'h5 |=> !rdata_o[7])
    else $error("status top bit set");
  AST_IE_TOP: assert property (rd_i && addr_i == 3'h1 && !dlab_i |=> rdata_o == {4'h0, $past(ie_q)})
    else $error("enable mask readback wrong");
  AST_ID_CODE: assert property (rd_i && addr_i == 3'h2
    |=> rdata_o[7:3] == 5'h00 && (!rdata_o[0] || rdata_o[2:1] == 2'h0))
    else $error("illegal identification code");
endmodule
bind uart_status_interrupt_modem_ctrl uart_sim_checker chk_i (.clock_i, .nrst_i, .addr_i, .rd_i, .wr_i,
  .wdata_i, .rdata_o, .dlab_i, .tx_load_i, .tx_serial_i, .tx_holding_o, .tx_holding_full_o,
  .rx_serial_o, .serial_out_o, .dtr_out_n_o, .rts_out_n_o, .irq_output_o);

// ### verilog/uart_status_interrupt_modem_ctrl.v
`include "uart_status_defs.vh"

// Notes on behaviour
// (RULE1) Assembled character sets receive ready
// (RULE2) Buffer read or zero write clears ready
// (RULE3) Unread buffer overwritten sets overrun flag
// (RULE4) Bad parity sets flag, status read clears
// (RULE5) Spacing stop bit sets framing error
// (RULE6) Spacing beyond one character time sets break
// (RULE7) Any receive error raises line status source
// (RULE8) Holding empty sets on transfer, clears on load
// (RULE9) Shifter empty while idle, clears on transfer
// (RULE10) Unused upper status and enable bits read zero
// (RULE11) Priority: line, data, holding empty, modem
// (RULE12) Identification frozen while being accessed
// (RULE13) Identification bit zero high when none pending
// (RULE14) Identification codes 001 110 100 010 000
// (RULE15) Holding empty source cleared by id read, write
// (RULE16) Each source cleared by its register read; holding empty is cleared by an id read or a holding write instead
// (RULE17) Each source gated by its enable bit
// (RULE18) Disabled sources hidden from id and output
// (RULE19) Interrupt output high when enabled pending
// (RULE20) Modem control bits drive inverted modem pins
// (RULE21) Loopback marks output, loops transmit to receive
// (RULE22) Loopback routes control bits to modem inputs
// (RULE23) Loopback pairs rts-cts, dtr-dsr, aux-ring-carrier
// (RULE24) Modem input change sets delta, status read clears
// (RULE25) Status read also clears framing and break
// (RULE26) Loopback holds external modem pins inactive high
module uart_status_interrupt_modem_ctrl #(
  parameter CNT_W = 5                       // Break counter width
) (
  input  wire       clock_i,                // System clock
  input  wire       nrst_i,                 // Master reset, active low
  // Host register port
  input  wire       sel_i,                  // Chip selected, level
  input  wire [2:0] addr_i,                 // Register address
  input  wire       rd_i,                   // Read strobe, one cycle
  input  wire       wr_i,                   // Write strobe, one cycle
  input  wire [7:0] wdata_i,                // Write data
  output reg  [7:0] rdata_o,                // Read data, registered
  // Line control settings from the surrounding element
  input  wire       dlab_i,                 // Divisor latch access
  input  wire [1:0] word_len_i,             // 0..3 gives 5..8 bits
  input  wire       two_stop_i,             // Extra stop bit
  input  wire       parity_en_i,            // Parity checked
  input  wire       even_parity_i,          // Even parity selected
  input  wire       bit_tick_i,             // One pulse per bit time
  // Receiver side
  input  wire       rx_char_valid_i,        // Character assembled
  input  wire [7:0] rx_char_i,              // Assembled data bits
  input  wire       rx_parity_bit_i,        // Received parity bit
  input  wire       rx_stop_bit_i,          // Sampled stop bit level
  output reg        rx_serial_o,            // Line into receiver
  // Transmitter side
  input  wire       tx_load_i,              // Holding moved to shifter
  input  wire       tx_shifter_idle_i,      // Shifter has nothing to send
  input  wire       tx_serial_i,            // Shifter serial output
  output reg  [7:0] tx_holding_o,           // Holding register data
  output reg        tx_holding_full_o,      // Holding register loaded
  // Serial pins
  input  wire       serial_in_i,            // Serial line in
  output reg        serial_out_o,           // Serial line out
  // Modem pins, active low
  input  wire       cts_in_n_i,             // Clear to send
  input  wire       dsr_in_n_i,             // Data set ready
  input  wire       ring_in_n_i,            // Ring indicator
  input  wire       carrier_detect_in_n_i,  // Carrier detect
  output reg        dtr_out_n_o,            // Terminal ready
  output reg        rts_out_n_o,            // Request to send
  output reg        aux1_out_n_o,           // Auxiliary one
  output reg        aux2_out_n_o,           // Auxiliary two
  // Interrupt
  output reg        irq_output_o            // Interrupt, active high
);

  // =====================================================
  // Decoding helpers

  // Match a register address, with divisor latch gating
  function match;
    input [2:0] a;
    input       dl;
    input [2:0] code;
    begin
      if ((code == `ADDR_DATA) || (code == `ADDR_IE_MASK)) begin
        match = (a == code) && !dl;
      end else begin
        match = (a == code);
      end
    end
  endfunction

  // Data bits masked to the configured word length
  function [7:0] len_mask;
    input [1:0] wl;
    begin
      case (wl)
        2'h0:    len_mask = 8'h1f;
        2'h1:    len_mask = 8'h3f;
        2'h2:    len_mask = 8'h7f;
        default: len_mask = 8'hff;
      endcase
    end
  endfunction

  // =====================================================
  // Access decode

  wire rd_data  = rd_i && match(addr_i, dlab_i, `ADDR_DATA);       // Receive buffer read
  wire wr_data  = wr_i && match(addr_i, dlab_i, `ADDR_DATA);       // Holding register write
  wire wr_ie    = wr_i && match(addr_i, dlab_i, `ADDR_IE_MASK);    // Enable write
  wire rd_id    = rd_i && match(addr_i, dlab_i, `ADDR_INT_ID);     // Identification read
  wire wr_mc    = wr_i && match(addr_i, dlab_i, `ADDR_MODEM_CTRL); // Modem control write
  wire rd_ls    = rd_i && match(addr_i, dlab_i, `ADDR_LINE_STAT);  // Line status read
  wire wr_ls    = wr_i && match(addr_i, dlab_i, `ADDR_LINE_STAT);  // Line status write
  wire rd_ms    = rd_i && match(addr_i, dlab_i, `ADDR_MODEM_STAT); // Modem status read
  wire id_frz   = sel_i && match(addr_i, dlab_i, `ADDR_INT_ID);    // Identification addressed

  // =====================================================
  // State

  // Reset images, cut to the width of each register
  localparam [7:0] IE_RST = `RST_IE_MASK;
  localparam [7:0] MC_RST = `RST_MODEM_CTRL;
  localparam [7:0] ID_RST = `RST_INT_ID;

  reg [4:0]       sync1_q;       // First stage, read only by second
  reg [4:0]       sync2_q;       // Synchronised pins
  reg [7:0]       rbr_q;         // Receive holding buffer
  reg [3:0]       ie_q;          // Interrupt enable bits
  reg [4:0]       mc_q;          // Modem control bits
  reg             dr_q;          // Receive ready
  reg             oe_q;          // Overrun
  reg             pe_q;          // Parity error
  reg             fe_q;          // Framing error
  reg             bi_q;          // Break
  reg             tx_holding_empty_flag_q;        // Holding empty
  reg             tx_shifter_empty_flag_q;        // Shifter empty
  reg             tx_holding_empty_flag_irq_q;    // Holding empty interrupt pending
  reg [2:0]       id_q;          // Identification, frozen on access
  reg [3:0]       mstat_q;       // Modem line states, true sense
  reg [3:0]       delta_q;       // Modem change bits
  reg [CNT_W-1:0] brk_cnt_q;     // Spacing bit times counted
  reg             brk_done_q;    // Break already flagged this spell

  // =====================================================
  // Line selection and modem input sources

  wire       loop    = mc_q[`MC_LOOP];
  wire       sin_s   = sync2_q[4];                                 // Synchronised serial in
  wire       rx_line = loop ? tx_serial_i : sin_s;                 // (RULE21)
  // Order: cts, dsr, ring, carrier, true sense
  wire [3:0] pin_st  = ~sync2_q[3:0];
  wire [3:0] loop_st = {mc_q[`MC_AUX2], mc_q[`MC_AUX1], mc_q[`MC_DTR], mc_q[`MC_RTS]}; // (RULE23)
  wire [3:0] mstat_d = loop ? loop_st : pin_st;                    // (RULE22)

  // Two flip-flop synchroniser for pins
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
    end else begin
      sync1_q <= {serial_in_i, carrier_detect_in_n_i, ring_in_n_i, dsr_in_n_i, cts_in_n_i};
      sync2_q <= sync1_q;
    end
  end

  // =====================================================
  // Receive error checks

  wire [7:0] rx_m    = rx_char_i & len_mask(word_len_i);
  wire       par_x   = (^rx_m) ^ rx_parity_bit_i;
  wire       par_err = rx_char_valid_i && parity_en_i && (par_x ^ ~even_parity_i); // (RULE4)
  wire       frm_err = rx_char_valid_i && !rx_stop_bit_i;                          // (RULE5)

  // Character length in bit times: start, data, parity, stop
  wire [CNT_W-1:0] char_bits = `BITS_START + `BITS_MIN_DATA + {3'h0, word_len_i}
                               + {4'h0, parity_en_i} + (two_stop_i ? 5'h02 : 5'h01);
  wire brk_hit = !rx_line && bit_tick_i && !brk_done_q && (brk_cnt_q == char_bits);

  // Spacing time counter for break detection
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      brk_cnt_q  <= {CNT_W{1'b0}};
      brk_done_q <= 1'b0;
    end else if (rx_line) begin
      // Marking ends the spell and rearms
      brk_cnt_q  <= {CNT_W{1'b0}};
      brk_done_q <= 1'b0;
    end else if (bit_tick_i && !brk_done_q) begin
      brk_cnt_q  <= brk_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      brk_done_q <= brk_hit;                                       // (RULE6)
    end
  end

  // =====================================================
  // Line status flags, a set beats a clear in the same cycle, except shifter empty, where a transfer wins over idle

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dr_q   <= 1'b0;
      oe_q   <= 1'b0;
      pe_q   <= 1'b0;
      fe_q   <= 1'b0;
      bi_q   <= 1'b0;
      tx_holding_empty_flag_q <= 1'b1;
      tx_shifter_empty_flag_q <= 1'b1;
      rbr_q  <= 8'h00;
    end else begin
      // Receive ready
      if (rx_char_valid_i) begin
        dr_q <= 1'b1;                                              // (RULE1)
      end else if (rd_data || (wr_ls && !wdata_i[`LS_READY])) begin
        dr_q <= 1'b0;                                              // (RULE2)
      end
      // Overrun when the old character was never read
      if (rx_char_valid_i && dr_q && !rd_data) begin
        oe_q <= 1'b1;                                              // (RULE3)
      end else if (rd_ls) begin
        oe_q <= 1'b0;                                              // (RULE3)
      end
      // Parity error
      if (par_err) begin
        pe_q <= 1'b1;
      end else if (rd_ls) begin
        pe_q <= 1'b0;                                              // (RULE4)
      end
      // Framing error
      if (frm_err) begin
        fe_q <= 1'b1;
      end else if (rd_ls) begin
        fe_q <= 1'b0;                                              // (RULE25)
      end
      // Break
      if (brk_hit) begin
        bi_q <= 1'b1;
      end else if (rd_ls) begin
        bi_q <= 1'b0;                                              // (RULE25)
      end
      // Holding empty: transfer sets, host load clears
      if (tx_load_i) begin
        tx_holding_empty_flag_q <= 1'b1;                                            // (RULE8)
      end else if (wr_data) begin
        tx_holding_empty_flag_q <= 1'b0;                                            // (RULE8)
      end
      // Shifter empty follows idle, cleared by a transfer
      tx_shifter_empty_flag_q <= tx_load_i ? 1'b0 : tx_shifter_idle_i;              // (RULE9)
      // New character overwrites the buffer
      if (rx_char_valid_i) begin
        rbr_q <= rx_char_i;
      end
    end
  end

  // =====================================================
  // Transmit holding register toward the transmitter

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_holding_o      <= 8'h00;
      tx_holding_full_o <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_holding_o <= wdata_i;
      end
      // Full follows the inverse of holding empty
      if (tx_load_i) begin
        tx_holding_full_o <= 1'b0;
      end else if (wr_data) begin
        tx_holding_full_o <= 1'b1;
      end
    end
  end

  // =====================================================
  // Enable and modem control registers

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ie_q <= IE_RST[3:0];
      mc_q <= MC_RST[4:0];
    end else begin
      if (wr_ie) begin
        ie_q <= wdata_i[3:0];
      end
      if (wr_mc) begin
        mc_q <= wdata_i[4:0];
      end
    end
  end

  // =====================================================
  // Modem status: line states and change detection

  wire [3:0] chg;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_delta
      if (gi == 2) begin : g_ring
        // Ring counts only its trailing edge
        assign chg[gi] = mstat_q[gi] && !mstat_d[gi];
      end else begin : g_any
        assign chg[gi] = mstat_q[gi] ^ mstat_d[gi];
      end
      // Change sets, status read clears, set wins
      always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          delta_q[gi] <= 1'b0;
        end else if (chg[gi]) begin
          delta_q[gi] <= 1'b1;                                     // (RULE24)
        end else if (rd_ms) begin
          delta_q[gi] <= 1'b0;                                     // (RULE24)
        end
      end
    end
  endgenerate

  // Line state tracking
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mstat_q <= 4'h0;
    end else begin
      mstat_q <= mstat_d;
    end
  end

  // =====================================================
  // Interrupt sources, enables and identification

  wire rls_src = oe_q || pe_q || fe_q || bi_q;                     // (RULE7)
  wire ms_src  = |delta_q;
  wire rls_on  = rls_src    && ie_q[`IE_LINE_STAT];                // (RULE17)
  wire rda_on  = dr_q       && ie_q[`IE_RX_DATA];                  // (RULE17)
  wire thr_on  = tx_holding_empty_flag_irq_q && ie_q[`IE_THR_EMPTY];                // (RULE17)
  wire ms_on   = ms_src     && ie_q[`IE_MODEM];                    // (RULE17)

  // Holding empty pending flag
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_holding_empty_flag_irq_q <= 1'b0;
    end else if (tx_load_i) begin
      tx_holding_empty_flag_irq_q <= 1'b1;
    end else if (wr_data || (rd_id && (id_q == `ID_THR_EMPTY))) begin
      tx_holding_empty_flag_irq_q <= 1'b0;                                          // (RULE15)
    end
  end

  // Highest priority enabled source
  reg [2:0] id_d;
  always @* begin
    id_d = `ID_NONE;                                               // (RULE13)
    if (rls_on) begin
      id_d = `ID_LINE_STAT;                                        // (RULE11)
    end else if (rda_on) begin
      id_d = `ID_RX_DATA;                                          // (RULE14)
    end else if (thr_on) begin
      id_d = `ID_THR_EMPTY;
    end else if (ms_on) begin
      id_d = `ID_MODEM;                                            // (RULE18)
    end
  end

  // Identification held while the host addresses it
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      id_q <= ID_RST[2:0];
    end else if (!id_frz) begin
      id_q <= id_d;                                                // (RULE12)
    end
  end

  // =====================================================
  // Host read data

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ADDR_DATA:       rdata_o <= dlab_i ? 8'h00 : rbr_q;       // (RULE16)
        `ADDR_IE_MASK:    rdata_o <= dlab_i ? 8'h00 : {4'h0, ie_q}; // (RULE10)
        `ADDR_INT_ID:     rdata_o <= {5'h00, id_q};
        `ADDR_MODEM_CTRL: rdata_o <= {3'h0, mc_q};
        `ADDR_LINE_STAT:  rdata_o <= {1'b0, tx_shifter_empty_flag_q, tx_holding_empty_flag_q, bi_q, fe_q, pe_q, oe_q, dr_q}; // (RULE10)
        `ADDR_MODEM_STAT: rdata_o <= {mstat_q[3], mstat_q[2], mstat_q[1], mstat_q[0], delta_q};
        default:          rdata_o <= 8'h00;
      endcase
    end
  end

  // =====================================================
  // Pin drivers

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_out_o <= 1'b1;
      rx_serial_o  <= 1'b1;
      dtr_out_n_o  <= 1'b1;
      rts_out_n_o  <= 1'b1;
      aux1_out_n_o <= 1'b1;
      aux2_out_n_o <= 1'b1;
      irq_output_o <= 1'b0;
    end else begin
      serial_out_o <= loop ? 1'b1 : tx_serial_i;                   // (RULE21)
      rx_serial_o  <= rx_line;                                     // (RULE21)
      dtr_out_n_o  <= loop ? 1'b1 : ~mc_q[`MC_DTR];                // (RULE20)
      rts_out_n_o  <= loop ? 1'b1 : ~mc_q[`MC_RTS];                // (RULE26)
      aux1_out_n_o <= loop ? 1'b1 : ~mc_q[`MC_AUX1];               // (RULE20)
      aux2_out_n_o <= loop ? 1'b1 : ~mc_q[`MC_AUX2];               // (RULE26)
      irq_output_o <= rls_on || rda_on || thr_on || ms_on;         // (RULE19)
    end
  end

endmodule
